// >>> hdl/aerus_regs.v
// error report capability header and uncorrectable error status registers
// assumes a simple one-cycle configuration access port and pulse events
// from the port's error detectors, all synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "aerus_defs.vh"

// Behaviour
// RULE_01 - capability id reads constant one, read-only
// RULE_02 - capability version reads constant one, read-only
// RULE_03 - next pointer lock-writable, zero ends list
// RULE_04 - obsolete bit zero sticky, never set
// RULE_05 - link protocol error sets bit four
// RULE_06 - surprise down sets bit five when capable
// RULE_07 - poisoned packet sets bit twelve
// RULE_08 - flow control violation sets bit thirteen
// RULE_09 - completion timeout bit fourteen tied zero
// RULE_10 - completer abort never set; acs counted
// RULE_11 - unexpected completion sets bit sixteen
// RULE_12 - receive overflow sets bit seventeen
// RULE_13 - malformed packet sets bit eighteen
// RULE_14 - end-to-end crc failure sets bit nineteen
// RULE_15 - unsupported request sets bit twenty
// RULE_16 - access control violation sets bit twenty-one
// RULE_17 - internal error sets bit twenty-two
// RULE_18 - blocked multicast sets bit twenty-three
// RULE_19 - masks never stop status bits setting
// RULE_20 - sticky across warm reset; zero writes ignored
// RULE_21 - reserved bits read zero, ignore writes
module aerus_regs
#(
  parameter [11:0] NEXT_PTR_DEFAULT = `AERUS_NEXT_PTR_RST
)
(
  input  wire        clk,
  input  wire        rst,
  input  wire        cold_rst,
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [11:0] cfg_addr,
  input  wire [3:0]  cfg_be,
  input  wire [31:0] cfg_wdata,
  input  wire        write_lock,
  output reg  [31:0] cfg_rdata_q,
  output reg         cfg_ack_q,
  input  wire        link_protocol_error_flag,
  input  wire        surprise_down_flag,
  input  wire        surprise_down_report_capable,
  input  wire        poisoned_tlp_evt,
  input  wire        flow_credit_protocol_flag,
  input  wire        unexpected_completion_flag,
  input  wire        receiver_overflow_flag,
  input  wire        malformed_tlp_evt,
  input  wire        end_to_end_crc_flag,
  input  wire        unsupported_request_flag,
  input  wire        access_control_violation_flag,
  input  wire        internal_error_flag,
  input  wire        multicast_blocked_flag,
  output wire [31:0] status_vec
);

  ////////////////////////////////////////////////////////////////////////////
  // decode and byte-lane expansion

  wire        hdr_sel;
  wire        sts_sel;
  wire [31:0] be_mask;
  wire [31:0] clr_vec;
  wire [31:0] set_vec;
  wire [31:0] hdr_val;
  reg  [11:0] next_ptr_q;
  reg  [11:0] next_ptr_d;
  reg  [31:0] rdata_d;

  assign hdr_sel = (cfg_addr == `AERUS_OFF_CAP_HDR);
  assign sts_sel = (cfg_addr == `AERUS_OFF_UNC_STATUS);

  assign be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}},
                    {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // only ones in enabled lanes of implemented bits clear; zeros do nothing
  assign clr_vec = (cfg_wr && sts_sel) ?
                   (cfg_wdata & be_mask & `AERUS_STATUS_IMPL) :
                   32'h00000000; // [RULE_20] [RULE_21]

  ////////////////////////////////////////////////////////////////////////////
  // event map onto status positions; mask registers are not consulted here,
  // so masking can only ever affect logging further on

  assign set_vec[`AERUS_BIT_OBSOLETE]    = 1'b0; // [RULE_04]
  assign set_vec[3:1]                    = 3'h0;
  assign set_vec[`AERUS_BIT_LINK_PROTO]  =
         link_protocol_error_flag; // [RULE_05] [RULE_19]
  assign set_vec[`AERUS_BIT_SURPRISE]    =
         surprise_down_flag & surprise_down_report_capable; // [RULE_06]
  assign set_vec[11:6]                   = 6'h00;
  assign set_vec[`AERUS_BIT_POISONED]    = poisoned_tlp_evt; // [RULE_07]
  assign set_vec[`AERUS_BIT_FLOW_CREDIT] =
         flow_credit_protocol_flag; // [RULE_08]
  assign set_vec[`AERUS_BIT_COMPL_TO]    = 1'b0; // [RULE_09]
  // an abort due to acs arrives on the acs input, so this stays clear
  assign set_vec[`AERUS_BIT_COMPL_ABORT] = 1'b0; // [RULE_10]
  assign set_vec[`AERUS_BIT_UNEXP_COMPL] =
         unexpected_completion_flag; // [RULE_11]
  assign set_vec[`AERUS_BIT_RX_OVERFLOW] =
         receiver_overflow_flag; // [RULE_12]
  assign set_vec[`AERUS_BIT_MALFORMED]   = malformed_tlp_evt; // [RULE_13]
  assign set_vec[`AERUS_BIT_E2E_CRC]     = end_to_end_crc_flag; // [RULE_14]
  assign set_vec[`AERUS_BIT_UNSUPP_REQ]  =
         unsupported_request_flag; // [RULE_15]
  assign set_vec[`AERUS_BIT_ACS_VIOL]    =
         access_control_violation_flag; // [RULE_16] [RULE_10]
  assign set_vec[`AERUS_BIT_INTERNAL]    = internal_error_flag; // [RULE_17]
  assign set_vec[`AERUS_BIT_MC_BLOCKED]  =
         multicast_blocked_flag; // [RULE_18]
  assign set_vec[31:24]                  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, one cell per implemented position; every cell sits on
  // the cold reset only, so a warm reset of the port keeps logged errors

  // reserved and tied positions have no storage at all; the retired bit zero keeps a cell
  assign status_vec[3:1]                    = 3'h0; // [RULE_21]
  assign status_vec[11:6]                   = 6'h00; // [RULE_21]
  assign status_vec[`AERUS_BIT_COMPL_TO]    = 1'b0; // [RULE_09]
  assign status_vec[`AERUS_BIT_COMPL_ABORT] = 1'b0; // [RULE_10]
  assign status_vec[31:24]                  = 8'h00; // [RULE_21]

  // obsolete bit: software may clear it, but nothing ever sets it
  aerus_sticky_bit u_obsolete_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_OBSOLETE]),
    .clr_w1c    (clr_vec[`AERUS_BIT_OBSOLETE]),
    .flag_q     (status_vec[`AERUS_BIT_OBSOLETE])
  ); // [RULE_04] [RULE_20]

  // data link protocol error
  aerus_sticky_bit u_link_proto_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_LINK_PROTO]),
    .clr_w1c    (clr_vec[`AERUS_BIT_LINK_PROTO]),
    .flag_q     (status_vec[`AERUS_BIT_LINK_PROTO])
  ); // [RULE_05] [RULE_20]

  // surprise down, already gated by the reporting capability
  aerus_sticky_bit u_surprise_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_SURPRISE]),
    .clr_w1c    (clr_vec[`AERUS_BIT_SURPRISE]),
    .flag_q     (status_vec[`AERUS_BIT_SURPRISE])
  ); // [RULE_06] [RULE_20]

  // poisoned packet seen on the port
  aerus_sticky_bit u_poisoned_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_POISONED]),
    .clr_w1c    (clr_vec[`AERUS_BIT_POISONED]),
    .flag_q     (status_vec[`AERUS_BIT_POISONED])
  ); // [RULE_07] [RULE_20]

  // flow control protocol violation
  aerus_sticky_bit u_flow_credit_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_FLOW_CREDIT]),
    .clr_w1c    (clr_vec[`AERUS_BIT_FLOW_CREDIT]),
    .flag_q     (status_vec[`AERUS_BIT_FLOW_CREDIT])
  ); // [RULE_08] [RULE_20]

  // completion that matched no outstanding request
  aerus_sticky_bit u_unexp_compl_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_UNEXP_COMPL]),
    .clr_w1c    (clr_vec[`AERUS_BIT_UNEXP_COMPL]),
    .flag_q     (status_vec[`AERUS_BIT_UNEXP_COMPL])
  ); // [RULE_11] [RULE_20]

  // receive buffer overflow
  aerus_sticky_bit u_rx_overflow_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_RX_OVERFLOW]),
    .clr_w1c    (clr_vec[`AERUS_BIT_RX_OVERFLOW]),
    .flag_q     (status_vec[`AERUS_BIT_RX_OVERFLOW])
  ); // [RULE_12] [RULE_20]

  // malformed packet
  aerus_sticky_bit u_malformed_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_MALFORMED]),
    .clr_w1c    (clr_vec[`AERUS_BIT_MALFORMED]),
    .flag_q     (status_vec[`AERUS_BIT_MALFORMED])
  ); // [RULE_13] [RULE_20]

  // end-to-end crc failure
  aerus_sticky_bit u_e2e_crc_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_E2E_CRC]),
    .clr_w1c    (clr_vec[`AERUS_BIT_E2E_CRC]),
    .flag_q     (status_vec[`AERUS_BIT_E2E_CRC])
  ); // [RULE_14] [RULE_20]

  // unsupported request
  aerus_sticky_bit u_unsupp_req_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_UNSUPP_REQ]),
    .clr_w1c    (clr_vec[`AERUS_BIT_UNSUPP_REQ]),
    .flag_q     (status_vec[`AERUS_BIT_UNSUPP_REQ])
  ); // [RULE_15] [RULE_20]

  // access control violation, which also takes the acs-driven aborts
  aerus_sticky_bit u_acs_viol_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_ACS_VIOL]),
    .clr_w1c    (clr_vec[`AERUS_BIT_ACS_VIOL]),
    .flag_q     (status_vec[`AERUS_BIT_ACS_VIOL])
  ); // [RULE_16] [RULE_20]

  // uncorrectable internal error of this port
  aerus_sticky_bit u_internal_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_INTERNAL]),
    .clr_w1c    (clr_vec[`AERUS_BIT_INTERNAL]),
    .flag_q     (status_vec[`AERUS_BIT_INTERNAL])
  ); // [RULE_17] [RULE_20]

  // multicast packet blocked at ingress
  aerus_sticky_bit u_mc_blocked_bit
  (
    .clk        (clk),
    .sticky_rst (cold_rst),
    .set_evt    (set_vec[`AERUS_BIT_MC_BLOCKED]),
    .clr_w1c    (clr_vec[`AERUS_BIT_MC_BLOCKED]),
    .flag_q     (status_vec[`AERUS_BIT_MC_BLOCKED])
  ); // [RULE_18] [RULE_20]

  ////////////////////////////////////////////////////////////////////////////
  // next capability pointer: writable only while the lock is open

  always @*
  begin
    next_ptr_d = next_ptr_q;
    if (cfg_wr && hdr_sel && !write_lock)
    begin
      // the field straddles lanes two and three; each half obeys its lane
      if (cfg_be[2])
        next_ptr_d[3:0] = cfg_wdata[`AERUS_NEXT_PTR_LSB +: 4];
      if (cfg_be[3])
        next_ptr_d[11:4] = cfg_wdata[`AERUS_NEXT_PTR_LSB + 4 +: 8];
    end
  end

  // warm reset restores the default; the lock guards it afterwards
  always @(posedge clk)
  begin
    if (rst)
      next_ptr_q <= NEXT_PTR_DEFAULT;
    else
      next_ptr_q <= next_ptr_d; // [RULE_03]
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data; identifier and version are wired constants

  assign hdr_val = {next_ptr_q, `AERUS_CAP_VER_VAL,
                    `AERUS_CAP_ID_VAL}; // [RULE_01] [RULE_02] [RULE_03]

  // unmapped offsets read zero so a walk of the list never sees junk
  always @*
  begin
    rdata_d = 32'h00000000;
    if (cfg_rd && hdr_sel)
      rdata_d = hdr_val;
    else if (cfg_rd && sts_sel)
      rdata_d = status_vec; // [RULE_21]
  end

  // answer one cycle after any access, read or write, mapped or not
  always @(posedge clk)
  begin
    if (rst)
    begin
      cfg_rdata_q <= 32'h00000000;
      cfg_ack_q   <= 1'b0;
    end
    else
    begin
      cfg_rdata_q <= rdata_d;
      cfg_ack_q   <= cfg_rd | cfg_wr;
    end
  end

endmodule // aerus_regs

`default_nettype wire

// >>> hdl/aerus_sticky_bit.v
// one sticky write-one-to-clear status flag
// assumes the caller gates set and clear by the bit's own decode
`timescale 1ns/1ps
`default_nettype none

module aerus_sticky_bit
(
  input  wire clk,
  input  wire sticky_rst,
  input  wire set_evt,
  input  wire clr_w1c,
  output reg  flag_q
);

  reg flag_d;

  // set beats clear so an event in the clearing cycle is never lost
  always @*
  begin
    flag_d = flag_q;
    if (clr_w1c)
      flag_d = 1'b0;
    if (set_evt)
      flag_d = 1'b1;
  end

  // only the cold reset touches the flag; warm resets leave it
  always @(posedge clk)
  begin
    if (sticky_rst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule // aerus_sticky_bit

`default_nettype wire

// >>> include/aerus_defs.vh
// constants for the error report capability header and uncorrectable status
// assumes inclusion by bare name from design files
`ifndef AERUS_DEFS_VH
`define AERUS_DEFS_VH

`define AERUS_OFF_CAP_HDR      12'h100
`define AERUS_OFF_UNC_STATUS   12'h104

`define AERUS_CAP_ID_VAL       16'h0001
`define AERUS_CAP_VER_VAL      4'h1
`define AERUS_NEXT_PTR_RST     12'h000

`define AERUS_CAP_ID_LSB       0
`define AERUS_CAP_VER_LSB      16
`define AERUS_NEXT_PTR_LSB     20

`define AERUS_BIT_OBSOLETE     0
`define AERUS_BIT_LINK_PROTO   4
`define AERUS_BIT_SURPRISE     5
`define AERUS_BIT_POISONED     12
`define AERUS_BIT_FLOW_CREDIT  13
`define AERUS_BIT_COMPL_TO     14
`define AERUS_BIT_COMPL_ABORT  15
`define AERUS_BIT_UNEXP_COMPL  16
`define AERUS_BIT_RX_OVERFLOW  17
`define AERUS_BIT_MALFORMED    18
`define AERUS_BIT_E2E_CRC      19
`define AERUS_BIT_UNSUPP_REQ   20
`define AERUS_BIT_ACS_VIOL     21
`define AERUS_BIT_INTERNAL     22
`define AERUS_BIT_MC_BLOCKED   23

// implemented status bits, each clearable by a write: 0, 4, 5, 12, 13, 16..23
`define AERUS_STATUS_IMPL      32'h00FF3031
`define AERUS_STATUS_RST       32'h00000000

`endif

// >>> sim/aerus_detect_model.sv
// detector stand-in: one request bit becomes one event pulse
// assumes requests change at the falling clock edge
`timescale 1ns/1ps
`default_nettype none
module aerus_detect_model
(
  input  wire logic        clk,
  input  wire logic [11:0] req,
  output var  logic [11:0] evt_q
);
  // launched after the rising edge, as a real detector flop would be
  always @(posedge clk)
    evt_q <= req;
endmodule // aerus_detect_model
`default_nettype wire

// >>> sim/aerus_monitor.sv
// checker on the error status block ports
// assumes one clock domain; bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module aerus_monitor
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cold_rst,
  input wire logic        cfg_wr,
  input wire logic        cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic        unsupported_request_flag,
  input wire logic [31:0] cfg_rdata_q,
  input wire logic        cfg_ack_q,
  input wire logic [31:0] status_vec
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || cold_rst);
  // flags are undefined until cold reset, so both resets mute checks
  a_ack_follows: assert property (cfg_ack_q == $past(cfg_rd || cfg_wr))
    else $error("ack not one cycle after request");
  a_hdr_const: assert property (
    cfg_rd && !cfg_wr && cfg_addr == 12'h100
    |=> cfg_rdata_q[19:0] == 20'h10001) else $error("header id wrong");
  a_tied_zero: assert property (
    (status_vec & ~32'h00FF3031) == 32'h0) else $error("reserved bit set");
  a_bit0_never: assert property (!$rose(status_vec[0]))
    else $error("obsolete bit set");
  // warm reset stays live here: no flag may fall across it
  a_no_fall: assert property (
    disable iff (cold_rst)
    !$past(cold_rst) && |($past(status_vec) & ~status_vec)
    |-> $past(cfg_wr && cfg_addr == 12'h104)) else $error("flag lost");
  a_evt_sets: assert property (
    unsupported_request_flag |=> status_vec[20]) else $error("no flag");
  a_rd_status: assert property (
    cfg_rd && cfg_addr == 12'h104 |=> cfg_rdata_q == $past(status_vec))
    else $error("status read differs");
  a_unmapped_zero: assert property (
    cfg_rd && cfg_addr != 12'h100 && cfg_addr != 12'h104
    |=> cfg_rdata_q == 32'h0) else $error("unmapped read not zero");
endmodule // aerus_monitor
`default_nettype wire

// >>> sim/testbench.sv
// bench for the error status block: detector rows, then edge cases
// assumes the detector model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock starts low so no false falling edge shortens the reset count
  logic        clk = 1'b0;
  logic        rst, cold_rst, cfg_wr, cfg_rd, cap, wl, ack;
  logic [11:0] cfg_addr, req, ev, q;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, rdata, sv, v;
  int          n_mismatch, num_checks;
  // row i: event i raises this bit; last row is a surprise with the capability off, raising nothing
  int          pos [13] = '{5, 4, 12, 13, 16, 17, 18, 19, 20, 21, 22, 23, 32};
  aerus_regs dut
  (
    .clk(clk), .rst(rst), .cold_rst(cold_rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .write_lock(wl), .cfg_rdata_q(rdata),
    .cfg_ack_q(ack), .surprise_down_flag(ev[0]),
    .link_protocol_error_flag(ev[1]), .surprise_down_report_capable(cap),
    .poisoned_tlp_evt(ev[2]), .flow_credit_protocol_flag(ev[3]),
    .unexpected_completion_flag(ev[4]), .receiver_overflow_flag(ev[5]),
    .malformed_tlp_evt(ev[6]), .end_to_end_crc_flag(ev[7]),
    .unsupported_request_flag(ev[8]), .internal_error_flag(ev[10]),
    .access_control_violation_flag(ev[9]),
    .multicast_blocked_flag(ev[11]), .status_vec(sv)
  );
  aerus_detect_model u_det (.clk(clk), .req(req), .evt_q(ev));
  // a word result: read data or the live status vector
  task check_word(input string name, input logic [31:0] exp, seen);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // a single-bit result: the access acknowledge
  task check_bit(input string name, input logic exp, seen);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", name, exp, seen);
    end
  endtask
  // one access plus an optional event; ack and read data stand for the
  // cycle after the taking edge, so the falling edge inside it looks
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d, e,
           input logic [11:0] r = 12'h0, input logic [3:0] b = 4'hF);
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata, req} = {w, !w, a, b, d, r};
    @(negedge clk);
    {cfg_wr, cfg_rd, req} = 14'h0;
    check_bit("ack", 1'b1, ack);
    if (!w)
      check_word("rdata", e, rdata);
    // a read moves no flag, so the live vector must agree with it
    if (!w && a == 12'h104)
      check_word("status", e, sv);
    @(negedge clk);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // free-running clock, 100 ns
  initial
  begin
    forever #50 clk = ~clk;
  end
  // hang guard; the sequence needs about 150 cycles
  initial
  begin
    repeat (1000) @(posedge clk);
    n_mismatch++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: both resets, detector rows, then awkward cases
  initial
  begin
    {rst, cold_rst, cap, wl, cfg_wr, cfg_rd} = 6'b111000;
    {cfg_addr, cfg_be, cfg_wdata, req} = 60'h0;
    repeat (4) @(negedge clk);
    {rst, cold_rst} = 2'b00;
    acc(1'b0, 12'h100, 32'h0, 32'h00010001);
    for (int i = 0; i < 13; i++)
    begin
      cap = (i < 12);
      v = 32'h1 << pos[i];
      q = 12'h1 << (i % 12);
      acc(1'b1, 12'h104, 32'h0, 32'h0, q);
      acc(1'b0, 12'h104, 32'h0, v);
      acc(1'b1, 12'h104, v, 32'h0);
      acc(1'b0, 12'h104, 32'h0, 32'h0);
    end
    // next pointer takes writes only while unlocked
    acc(1'b1, 12'h100, 32'hFFFFFFFF, 32'h0);
    wl = 1'b1;
    acc(1'b1, 12'h100, 32'h0, 32'h0);
    acc(1'b0, 12'h100, 32'h0, 32'hFFF10001);
    // reserved and tied bits drop ones; unmapped space reads zero
    acc(1'b1, 12'h104, 32'hFFFFFFFF, 32'h0);
    acc(1'b0, 12'h104, 32'h0, 32'h0);
    acc(1'b0, 12'h108, 32'h0, 32'h0);
    // clear and event meet at one edge: the event must win
    req = 12'h100;
    @(negedge clk);
    acc(1'b1, 12'h104, 32'h00100000, 32'h0);
    acc(1'b0, 12'h104, 32'h0, 32'h00100000);
    // read and write together: old contents return, then the clear lands
    {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} =
      {2'b11, 12'h104, 4'hF, 32'h00100000};
    @(negedge clk);
    {cfg_wr, cfg_rd} = 2'b00;
    check_word("rdata", 32'h00100000, rdata);
    check_word("status", 32'h0, sv);
    @(negedge clk);
    // a flag survives warm reset and a clear with its lane off
    acc(1'b1, 12'h104, 32'h0, 32'h0, 12'h100);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    acc(1'b1, 12'h104, 32'h00100000, 32'h0, 12'h0, 4'hB);
    acc(1'b0, 12'h104, 32'h0, 32'h00100000);
    // warm reset brings the next pointer back to its default
    acc(1'b0, 12'h100, 32'h0, 32'h00010001);
    stop_test;
  end
endmodule // testbench
bind aerus_regs aerus_monitor u_mon
(
  .clk                      (clk),
  .rst                      (rst),
  .cold_rst                 (cold_rst),
  .cfg_wr                   (cfg_wr),
  .cfg_rd                   (cfg_rd),
  .cfg_addr                 (cfg_addr),
  .unsupported_request_flag (unsupported_request_flag),
  .cfg_rdata_q              (cfg_rdata_q),
  .cfg_ack_q                (cfg_ack_q),
  .status_vec               (status_vec)
);
`default_nettype wire
